// ==== led_fc_defs.svh ====
/*
 * Offsets, field positions, reset values and clock counts of the two
 * function-configuration registers and their status word.
 * Assumes inclusion by the package, the register bank and the bench.
 */
`ifndef LED_FC_DEFS_SVH
`define LED_FC_DEFS_SVH

`define ADDR_W          8
`define CFG1_LO_OFS     8'h00
`define CFG1_HI_OFS     8'h04
`define CFG2_LO_OFS     8'h08
`define CFG2_HI_OFS     8'h0c
`define STATUS_OFS      8'h10

`define CFG1_LO_RST     32'h0094a400
`define CFG1_HI_RST     32'h000000e0
`define CFG2_LO_RST     32'h00000666
`define CFG2_HI_RST     32'h00003b80
`define CFG1_LO_WMASK   32'hffffffff
`define CFG1_HI_WMASK   32'h00007fff
`define CFG2_LO_WMASK   32'hffffffff
`define CFG2_HI_WMASK   32'h0000bf8f

`define SEG_LSB         0
`define SMOOTH_LSB      10
`define BOOST_LSB       25
`define SWITCH_LSB      37
`define BLACK_LSB       41
`define PDC_LSB         0
`define DECOUPLE_LSB    12
`define COMP_LSB        24
`define STAT_SEG_LSB    0
`define STAT_SW_LSB     16

`define SEG_CODE_SHORT  10'h07f
`define SEG_CODE_LONG   10'h3ff
`define SEG_CLK_SHORT   11'h080
`define SEG_CLK_LONG    11'h400
`define SW_CLK_ZERO     9'h02d
`define SW_CLK_STEP     9'h01e
`define SW_CLK_RST      9'h0f0
`define SMOOTH_LVL_RST  6'h0a
`define PDC_CODE_RST    4'h6

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== led_fc_pkg.sv ====
/*
 * Types carried between the register bank and its users.
 * Assumes the defs header sits in the same folder.
 */
`include "led_fc_defs.svh"
package led_fc_pkg;
	typedef struct packed {
		logic [3:0] r;
		logic [3:0] g;
		logic [3:0] b;
	} rgb4_t;
	typedef struct packed {
		logic [4:0] r;
		logic [4:0] g;
		logic [4:0] b;
	} rgb5_t;
	typedef struct packed {
		logic [5:0] r;
		logic [5:0] g;
		logic [5:0] b;
	} rgb6_t;
endpackage

// ==== cfg_word.sv ====
/*
 * One 32-bit configuration word with byte strobes and a write mask.
 * Assumes the caller gives a one-cycle write pulse on its own clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cfg_word #(
	parameter logic [31:0] RESET = 32'h00000000,
	parameter logic [31:0] WMASK = 32'hffffffff
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// write side
	input  wire logic        i_we,
	input  wire logic [3:0]  i_strb,
	input  wire logic [31:0] i_wdata,
	// stored value
	output logic      [31:0] o_q
);
	logic [31:0] lane;
	logic [31:0] keep;
	logic [31:0] next_q;

	assign lane = {{8{i_strb[3]}}, {8{i_strb[2]}},
		{8{i_strb[1]}}, {8{i_strb[0]}}};
	// masked bits never load, so they keep their reset value for good
	assign keep = lane & WMASK;
	assign next_q = (o_q & ~keep) | (i_wdata & keep);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_q <= RESET;
		end else if (i_we) begin
			o_q <= next_q;
		end
	end
endmodule
`default_nettype wire

// ==== level_offset.sv ====
/*
 * Turns a level code into its one-based level number.
 * Assumes nothing; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module level_offset #(
	parameter int W = 4
) (
	// code in
	input  wire logic [W-1:0] i_code,
	// level out
	output logic      [W:0]   o_level
);
	assign o_level = {1'b0, i_code} + {{W{1'b0}}, 1'b1};
endmodule
`default_nettype wire

// ==== led_matrix_function_config_regs.sv ====
/*
 * Function-configuration register bank of the matrix driver: two 48-bit
 * configuration registers, each split over two 32-bit words, plus a
 * read-only status word, on an AXI4-Lite slave. Decoded settings leave
 * as registered outputs.
 * Assumes a master that keeps AXI4-Lite rules and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "led_fc_defs.svh"
module led_matrix_function_config_regs
	import led_fc_pkg::*;
(
	// clock and reset
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_SYS_RST,
	// write address channel
	input  wire logic [7:0]  I_AWADDR,
	input  wire logic [2:0]  I_AWPROT,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	// write data channel
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	// write response channel
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	// read address channel
	input  wire logic [7:0]  I_ARADDR,
	input  wire logic [2:0]  I_ARPROT,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	// read data channel
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	// decoded settings
	output logic [10:0]      O_SEGMENT_CLOCK_COUNT,
	output rgb6_t            O_LOWGRAY_SMOOTHING,
	output rgb4_t            O_LOWGRAY_BOOST,
	output logic [8:0]       O_SCAN_LINE_SWITCH_TIME,
	output logic [5:0]       O_BLACK_FIELD_ADJUST,
	output rgb4_t            O_PREDISCHARGE_LEVEL,
	output rgb5_t            O_DECOUPLING_LEVEL,
	output rgb5_t            O_LOWGRAY_COMPENSATION
);
	// write path state
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        bvalid;
	logic [1:0]  bresp;
	// read path state
	logic        rvalid;
	logic [1:0]  rresp;
	logic [31:0] rdata;

	// configuration words
	logic [31:0] cfg1_lo;
	logic [31:0] cfg1_hi;
	logic [31:0] cfg2_lo;
	logic [31:0] cfg2_hi;
	logic [47:0] cfg1;
	logic [47:0] cfg2;

	// bus decode
	logic        aw_fire;
	logic        w_fire;
	logic        wr_go;
	logic        ar_fire;
	logic [7:0]  wr_word;
	logic [7:0]  rd_word;
	logic        wr_c1l;
	logic        wr_c1h;
	logic        wr_c2l;
	logic        wr_c2h;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_mux;
	logic [31:0] status;

	// field views; per-colour slices are nets, one driver per element
	logic [9:0]           segment_clock_count;
	wire logic [2:0][4:0] smooth_code;
	wire logic [2:0][5:0] smooth_lvl;
	logic [3:0]           red_lowgray_boost;
	logic [3:0]           green_lowgray_boost;
	logic [3:0]           blue_lowgray_boost;
	logic [3:0]           scan_line_switch_time;
	logic [5:0]           black_field_adjust;
	logic [3:0]           red_predischarge_level;
	logic [3:0]           green_predischarge_level;
	logic [3:0]           blue_predischarge_level;
	wire logic [2:0][3:0] decouple_code;
	wire logic [2:0][4:0] decouple_lvl;
	wire logic [2:0][3:0] comp_code;
	wire logic [2:0][4:0] comp_lvl;

	// decoded next values
	logic [10:0] next_seg_clk;
	logic [4:0]  sw_mult;
	logic [8:0]  sw_prod;
	logic [8:0]  next_sw_clk;

	// AXI4-Lite write channels; address and data may arrive in any order
	assign O_AWREADY = !aw_held && !bvalid;
	assign O_WREADY  = !w_held && !bvalid;
	assign aw_fire   = I_AWVALID && O_AWREADY;
	assign w_fire    = I_WVALID && O_WREADY;
	assign wr_go     = aw_held && w_held && !bvalid;
	assign O_BVALID  = bvalid;
	assign O_BRESP   = bresp;

	assign wr_word = {aw_addr[7:2], 2'b00};
	assign wr_c1l  = wr_go && (wr_word == `CFG1_LO_OFS);
	assign wr_c1h  = wr_go && (wr_word == `CFG1_HI_OFS);
	assign wr_c2l  = wr_go && (wr_word == `CFG2_LO_OFS);
	assign wr_c2h  = wr_go && (wr_word == `CFG2_HI_OFS);
	assign wr_hit  = wr_c1l || wr_c1h || wr_c2l || wr_c2h;

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (aw_fire) begin
			aw_held <= 1'b1;
			aw_addr <= I_AWADDR;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (w_fire) begin
			w_held <= 1'b1;
			w_data <= I_WDATA;
			w_strb <= I_WSTRB;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end
	end

	// the status word and holes in the map refuse writes with SLVERR
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (I_BREADY) begin
			bvalid <= 1'b0;
		end
	end

	// read channel: one outstanding read, answered one cycle after ar
	assign O_ARREADY = !rvalid;
	assign ar_fire   = I_ARVALID && O_ARREADY;
	assign rd_word   = {I_ARADDR[7:2], 2'b00};
	assign rd_hit    = (rd_word == `CFG1_LO_OFS) ||
		(rd_word == `CFG1_HI_OFS) || (rd_word == `CFG2_LO_OFS) ||
		(rd_word == `CFG2_HI_OFS) || (rd_word == `STATUS_OFS);
	assign rd_mux =
		(rd_word == `CFG1_LO_OFS) ? cfg1_lo :
		(rd_word == `CFG1_HI_OFS) ? cfg1_hi :
		(rd_word == `CFG2_LO_OFS) ? cfg2_lo :
		(rd_word == `CFG2_HI_OFS) ? cfg2_hi :
		(rd_word == `STATUS_OFS)  ? status  : 32'h00000000;
	assign O_RVALID = rvalid;
	assign O_RRESP  = rresp;
	assign O_RDATA  = rdata;

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			rvalid <= 1'b0;
			rresp  <= `RESP_OKAY;
			rdata  <= 32'h00000000;
		end else if (ar_fire) begin
			rvalid <= 1'b1;
			rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			rdata  <= rd_mux;
		end else if (I_RREADY) begin
			rvalid <= 1'b0;
		end
	end

	// the four storage words; reserved bits are masked off
	cfg_word #(.RESET(`CFG1_LO_RST), .WMASK(`CFG1_LO_WMASK)) u_c1l (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_SYS_RST),
		.i_we    (wr_c1l),
		.i_strb  (w_strb),
		.i_wdata (w_data),
		.o_q     (cfg1_lo)
	);
	cfg_word #(.RESET(`CFG1_HI_RST), .WMASK(`CFG1_HI_WMASK)) u_c1h (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_SYS_RST),
		.i_we    (wr_c1h),
		.i_strb  (w_strb),
		.i_wdata (w_data),
		.o_q     (cfg1_hi)
	);
	cfg_word #(.RESET(`CFG2_LO_RST), .WMASK(`CFG2_LO_WMASK)) u_c2l (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_SYS_RST),
		.i_we    (wr_c2l),
		.i_strb  (w_strb),
		.i_wdata (w_data),
		.o_q     (cfg2_lo)
	);
	cfg_word #(.RESET(`CFG2_HI_RST), .WMASK(`CFG2_HI_WMASK)) u_c2h (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_SYS_RST),
		.i_we    (wr_c2h),
		.i_strb  (w_strb),
		.i_wdata (w_data),
		.o_q     (cfg2_hi)
	);

	assign cfg1 = {cfg1_hi[15:0], cfg1_lo};
	assign cfg2 = {cfg2_hi[15:0], cfg2_lo};

	// field extraction
	assign segment_clock_count = cfg1[`SEG_LSB +: 10];
	assign red_lowgray_boost   = cfg1[`BOOST_LSB +: 4];
	assign green_lowgray_boost = cfg1[`BOOST_LSB + 4 +: 4];
	assign blue_lowgray_boost  = cfg1[`BOOST_LSB + 8 +: 4];
	assign scan_line_switch_time = cfg1[`SWITCH_LSB +: 4];
	assign black_field_adjust    = cfg1[`BLACK_LSB +: 6];
	assign red_predischarge_level   = cfg2[`PDC_LSB +: 4];
	assign green_predischarge_level = cfg2[`PDC_LSB + 4 +: 4];
	assign blue_predischarge_level  = cfg2[`PDC_LSB + 8 +: 4];

	// index 0 red, 1 green, 2 blue
	generate
		for (genvar c = 0; c < 3; c++) begin : g_colour
			assign smooth_code[c]   = cfg1[`SMOOTH_LSB + 5*c +: 5];
			assign decouple_code[c] = cfg2[`DECOUPLE_LSB + 4*c +: 4];
			assign comp_code[c]     = cfg2[`COMP_LSB + 4*c +: 4];
			level_offset #(.W(5)) u_smooth (
				.i_code  (smooth_code[c]),
				.o_level (smooth_lvl[c])
			);
			level_offset #(.W(4)) u_decouple (
				.i_code  (decouple_code[c]),
				.o_level (decouple_lvl[c])
			);
			level_offset #(.W(4)) u_comp (
				.i_code  (comp_code[c]),
				.o_level (comp_lvl[c])
			);
		end
	endgenerate

	// only the long code selects 1024; any unlisted code stays at 128
	assign next_seg_clk = (segment_clock_count == `SEG_CODE_LONG) ?
		`SEG_CLK_LONG : `SEG_CLK_SHORT;
	assign sw_mult = {1'b0, scan_line_switch_time} + 5'h01;
	assign sw_prod = {4'h0, sw_mult} * `SW_CLK_STEP;
	// code zero is the odd one out, 45 clocks instead of 30 on the 30-clock grid
	assign next_sw_clk = (scan_line_switch_time == 4'h0) ?
		`SW_CLK_ZERO : sw_prod;

	assign status = {7'h00, O_SCAN_LINE_SWITCH_TIME,
		5'h00, O_SEGMENT_CLOCK_COUNT};

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_SEGMENT_CLOCK_COUNT   <= `SEG_CLK_SHORT;
			O_SCAN_LINE_SWITCH_TIME <= `SW_CLK_RST;
			O_BLACK_FIELD_ADJUST    <= 6'h00;
		end else begin
			O_SEGMENT_CLOCK_COUNT   <= next_seg_clk;
			O_SCAN_LINE_SWITCH_TIME <= next_sw_clk;
			O_BLACK_FIELD_ADJUST    <= black_field_adjust;
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_LOWGRAY_SMOOTHING <= '{`SMOOTH_LVL_RST,
				`SMOOTH_LVL_RST, `SMOOTH_LVL_RST};
			O_LOWGRAY_BOOST <= '{4'h0, 4'h0, 4'h0};
		end else begin
			O_LOWGRAY_SMOOTHING <= '{smooth_lvl[0], smooth_lvl[1],
				smooth_lvl[2]};
			O_LOWGRAY_BOOST <= '{red_lowgray_boost,
				green_lowgray_boost, blue_lowgray_boost};
		end
	end

	// the code passes unclamped: keeping it below supply is the host's job
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_PREDISCHARGE_LEVEL <= '{`PDC_CODE_RST, `PDC_CODE_RST,
				`PDC_CODE_RST};
		end else begin
			O_PREDISCHARGE_LEVEL <= '{red_predischarge_level,
				green_predischarge_level,
				blue_predischarge_level};
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_DECOUPLING_LEVEL     <= '{5'h01, 5'h01, 5'h01};
			O_LOWGRAY_COMPENSATION <= '{5'h01, 5'h01, 5'h01};
		end else begin
			O_DECOUPLING_LEVEL <= '{decouple_lvl[0], decouple_lvl[1],
				decouple_lvl[2]};
			O_LOWGRAY_COMPENSATION <= '{comp_lvl[0], comp_lvl[1],
				comp_lvl[2]};
		end
	end

	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_SYS_RST);

	a_seg_long: assert property (
		(segment_clock_count == 10'h3ff) |=>
		(O_SEGMENT_CLOCK_COUNT == 11'h400))
		else $error("long segment code did not give 1024 clocks");
	a_seg_short: assert property (
		(segment_clock_count != 10'h3ff) |=>
		(O_SEGMENT_CLOCK_COUNT == 11'h080))
		else $error("segment code did not give 128 clocks");
	a_smooth_level: assert property (
		##1 (O_LOWGRAY_SMOOTHING.g ==
		{1'b0, $past(cfg1[19:15])} + 6'h01))
		else $error("green smoothing level is not code plus one");
	a_boost_level: assert property (
		##1 (O_LOWGRAY_BOOST.b == $past(cfg1[36:33])))
		else $error("blue boost level differs from its code");
	a_switch_zero: assert property (
		(cfg1[40:37] == 4'h0) |=> (O_SCAN_LINE_SWITCH_TIME == 9'd45))
		else $error("switch code zero did not give 45 clocks");
	a_switch_step: assert property (
		(cfg1[40:37] == 4'hf) |=> (O_SCAN_LINE_SWITCH_TIME == 9'd480))
		else $error("switch code fifteen did not give 480 clocks");
	a_black_adjust: assert property (
		$changed(cfg1[46:41]) |=>
		(O_BLACK_FIELD_ADJUST == $past(cfg1[46:41])))
		else $error("black adjust did not follow its field");
	a_pdc_red: assert property (
		##1 (O_PREDISCHARGE_LEVEL.r == $past(cfg2[3:0])))
		else $error("red pre-discharge code mismatch");
	a_pdc_green_blue: assert property (
		##1 (O_PREDISCHARGE_LEVEL.g == $past(cfg2[7:4]) &&
		O_PREDISCHARGE_LEVEL.b == $past(cfg2[11:8])))
		else $error("green or blue pre-discharge code mismatch");
	a_decouple_level: assert property (
		##1 (O_DECOUPLING_LEVEL.r == {1'b0, $past(cfg2[15:12])} + 5'h01))
		else $error("red decoupling level is not code plus one");
	a_comp_red: assert property (
		##1 (O_LOWGRAY_COMPENSATION.r ==
		{1'b0, $past(cfg2[27:24])} + 5'h01))
		else $error("red compensation level is not code plus one");
	a_comp_blue: assert property (
		##1 (O_LOWGRAY_COMPENSATION.b ==
		{1'b0, $past(cfg2[35:32])} + 5'h01))
		else $error("blue compensation level is not code plus one");
	a_reserved_fixed: assert property (
		wr_go |=> (cfg1_hi[31:15] == 17'h00000 &&
		cfg2_hi[6:4] == 3'h0 && cfg2_hi[14] == 1'b0 &&
		cfg2_hi[31:16] == 16'h0000))
		else $error("reserved bit changed after a write");

	c_write_cfg1: cover property (wr_c1l ##1 bvalid);
	c_read_status: cover property (ar_fire && rd_word == `STATUS_OFS);
	c_bad_read: cover property (ar_fire && !rd_hit);
	c_seg_long: cover property (O_SEGMENT_CLOCK_COUNT == 11'h400);
endmodule
`default_nettype wire

// ==== led_host_model.sv ====
/*
 * Host controller model: an AXI4-Lite master whose tasks the bench calls.
 * Assumes each task is entered just after a rising edge of i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
	// clock
	input  wire logic        i_clk,
	// write side
	output logic      [7:0]  o_awaddr,
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic      [31:0] o_wdata,
	output logic      [3:0]  o_wstrb,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	// read side
	output logic      [7:0]  o_araddr,
	output logic             o_arvalid,
	input  wire logic        i_arready,
	input  wire logic        i_rvalid,
	output logic             o_rready
);
	// cycles of hesitation before accepting an answer
	int stall = 0;

	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid} = '0;
		{o_bready, o_araddr, o_arvalid, o_rready} = '0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		o_awaddr <= a;
		o_wdata <= d;
		o_wstrb <= s;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge i_clk);
			// released address and data show the inverse; the strobes keep their value
			if (o_awvalid && i_awready) begin
				aw_ok = 1'b1;
				o_awvalid <= 1'b0;
				o_awaddr <= ~a;
			end
			if (o_wvalid && i_wready) begin
				w_ok = 1'b1;
				o_wvalid <= 1'b0;
				o_wdata <= ~d;
			end
		end
		repeat (stall) @(posedge i_clk);
		o_bready <= 1'b1;
		do @(posedge i_clk); while (!i_bvalid);
		o_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		do @(posedge i_clk); while (!i_arready);
		o_arvalid <= 1'b0;
		o_araddr <= ~a;
		repeat (stall) @(posedge i_clk);
		o_rready <= 1'b1;
		do @(posedge i_clk); while (!i_rvalid);
		o_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 * Self-checking bench for the function-configuration register bank.
 * Assumes the package, the design files and the host model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "led_fc_defs.svh"
module tb_top;
	import led_fc_pkg::*;

	localparam logic [47:0] CFG1_RST = 48'h00e00094a400;
	localparam logic [47:0] CFG2_RST = 48'h3b8000000666;
	localparam logic [9:0]  SEGS [4] = '{10'h07f, 10'h3ff, 10'h000, 10'h3fe};

	logic              clk;
	logic              rst;
	int                fails = 0;
	int                n_checks = 0;
	int                cycles = 0;
	logic [31:0]       lo, hi, d;
	logic [47:0]       c1, c2;
	logic [33:0]       rq [$];
	logic [1:0]        bq [$];
	wire logic [7:0]   awaddr, araddr;
	wire logic [31:0]  wdata, rdata;
	wire logic [3:0]   wstrb;
	wire logic [1:0]   bresp, rresp;
	wire logic         awvalid, awready, wvalid, wready, bvalid, bready;
	wire logic         arvalid, arready, rvalid, rready;
	wire logic [10:0]  seg;
	wire logic [8:0]   swt;
	wire logic [5:0]   black;
	wire rgb6_t        smooth;
	wire rgb4_t        boost, pdc;
	wire rgb5_t        decpl, comp;

	led_matrix_function_config_regs DUT (
		.I_SYS_CLK(clk), .I_SYS_RST(rst),
		.I_AWADDR(awaddr), .I_AWPROT(3'h0), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
		.O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
		.I_ARPROT(3'h0), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
		.I_RREADY(rready), .O_SEGMENT_CLOCK_COUNT(seg),
		.O_LOWGRAY_SMOOTHING(smooth), .O_LOWGRAY_BOOST(boost),
		.O_SCAN_LINE_SWITCH_TIME(swt), .O_BLACK_FIELD_ADJUST(black),
		.O_PREDISCHARGE_LEVEL(pdc), .O_DECOUPLING_LEVEL(decpl),
		.O_LOWGRAY_COMPENSATION(comp));

	led_host_model host (
		.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb),
		.o_wvalid(wvalid), .i_wready(wready), .i_bvalid(bvalid),
		.o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
		.i_arready(arready), .i_rvalid(rvalid), .o_rready(rready));

	always #2.5 clk = ~clk;

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [47:0] exp,
		input logic [47:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [10:0] seg_of(input logic [47:0] v);
		return (v[9:0] == 10'h3ff) ? 11'h400 : 11'h080;
	endfunction

	function automatic logic [8:0] sw_of(input logic [47:0] v);
		return (v[40:37] == 4'h0) ? 9'h02d : (v[40:37] + 9'h001) * 9'h01e;
	endfunction

	task automatic chk_cfg1(input logic [47:0] v);
		rgb6_t s;
		s = {v[14:10] + 6'h01, v[19:15] + 6'h01, v[24:20] + 6'h01};
		chk("segment clocks", seg_of(v), seg);
		chk("smoothing", s, smooth);
		chk("boost", {v[28:25], v[32:29], v[36:33]}, boost);
		chk("switch time", sw_of(v), swt);
		chk("black field", v[46:41], black);
	endtask

	task automatic chk_cfg2(input logic [47:0] v);
		rgb5_t e;
		rgb5_t m;
		e = {v[15:12] + 5'h01, v[19:16] + 5'h01, v[23:20] + 5'h01};
		m = {v[27:24] + 5'h01, v[31:28] + 5'h01, v[35:32] + 5'h01};
		chk("predischarge", {v[3:0], v[7:4], v[11:8]}, pdc);
		chk("decoupling", e, decpl);
		chk("compensation", m, comp);
	endtask

	task automatic rd_exp(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] r);
		rq.push_back({r, v});
		host.rd(a);
	endtask

	task automatic wr_exp(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s, input logic [1:0] r);
		bq.push_back(r);
		host.wr(a, v, s);
	endtask

	// answers are matched in order against the notes left by the driver
	always @(posedge clk) begin
		cycles++;
		if (rvalid && rready)
			chk("read data", rq.pop_front(), {rresp, rdata});
		if (bvalid && bready)
			chk("write response", bq.pop_front(), bresp);
		if (cycles == 20000) begin
			fails++;
			final_report();
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		void'($urandom(32'h9d29759d));
		repeat (16) @(posedge clk);
		chk_cfg1(CFG1_RST);
		chk_cfg2(CFG2_RST);
		rst <= 1'b0;
		@(posedge clk);
		rd_exp(8'h00, CFG1_RST[31:0], `RESP_OKAY);
		rd_exp(8'h04, {16'h0, CFG1_RST[47:32]}, `RESP_OKAY);
		rd_exp(8'h08, CFG2_RST[31:0], `RESP_OKAY);
		rd_exp(8'h0c, {16'h0, CFG2_RST[47:32]}, `RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			host.stall = i % 3;
			lo = $urandom();
			hi = $urandom();
			lo[9:0] = SEGS[i % 4];
			hi[8:5] = i[3:0];
			c1 = {hi[15:0] & 16'h7fff, lo};
			wr_exp(8'h00, lo, 4'hf, `RESP_OKAY);
			wr_exp(8'h04, hi, 4'hf, `RESP_OKAY);
			repeat (2) @(posedge clk);
			chk_cfg1(c1);
			rd_exp(8'h04, {16'h0, c1[47:32]}, `RESP_OKAY);
			rd_exp(8'h10, {7'h0, sw_of(c1), 5'h0, seg_of(c1)},
				`RESP_OKAY);
			lo = $urandom();
			hi = $urandom();
			// codes above 1.1V could exceed a low colour supply
			for (int k = 0; k < 3; k++)
				if (lo[k*4 +: 4] > 4'ha)
					lo[k*4 +: 4] = 4'ha;
			c2 = {hi[15:0] & 16'hbf8f, lo};
			wr_exp(8'h08, lo, 4'hf, `RESP_OKAY);
			wr_exp(8'h0c, hi, 4'hf, `RESP_OKAY);
			repeat (2) @(posedge clk);
			chk_cfg2(c2);
			rd_exp(8'h0c, {16'h0, c2[47:32]}, `RESP_OKAY);
		end
		// a single byte lane leaves the other bytes alone
		d = $urandom();
		if (d[11:8] > 4'ha)
			d[11:8] = 4'ha;
		c2[15:8] = d[15:8];
		wr_exp(8'h08, d, 4'h2, `RESP_OKAY);
		repeat (2) @(posedge clk);
		chk_cfg2(c2);
		wr_exp(8'h10, $urandom(), 4'hf, `RESP_SLVERR);
		wr_exp(8'h14, $urandom(), 4'hf, `RESP_SLVERR);
		rd_exp(8'h14, 32'h0, `RESP_SLVERR);
		rd_exp(8'h00, c1[31:0], `RESP_OKAY);
		rd_exp(8'h08, c2[31:0], `RESP_OKAY);
		chk_cfg1(c1);
		chk_cfg2(c2);
		// second reset in mid-run restores every field
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk_cfg1(CFG1_RST);
		chk_cfg2(CFG2_RST);
		rst <= 1'b0;
		@(posedge clk);
		rd_exp(8'h0c, {16'h0, CFG2_RST[47:32]}, `RESP_OKAY);
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule
`default_nettype wire
